// ==== core/qcmd_pkg.sv ====
// Constants shared by the quadrature match/direction block.
// Assumes one clock and word registers on AHB-Lite.
// Contract
// RL1 - Reserved bits 15:14 read zero, write zero
// RL2 - Both compares equal sets combined match flag
// RL3 - Writing zero clears flag, one keeps it
// RL4 - Locked read-modify-write reads flags as one
// RL5 - Position mode leaving 00 with match sets flag
// RL6 - Count or compare write matching sets flag
// RL7 - Shared compare write matching sets flag
// RL8 - Revolution mode leaving 00 with match sets flag
// RL9 - Match flag ignores compare target select bit
// RL10 - Match flag and enable raise interrupt
// RL11 - Bit 11 holds direction at last wrap
// RL12 - Bit 10 holds direction of last step
// RL13 - Index before first step: reset, no revolution
// RL14 - Direction reversal sets reversal flag
// RL15 - No reversal flag for first step after 00
// RL16 - Reversal flag and enable raise interrupt
// RL17 - Maximum position: 16 bits, resets to ones
// RL18 - Up step at maximum flags overflow
// RL19 - Underflow reloads counter with maximum
// RL20 - Software never byte-accesses maximum position
// RL21 - Interrupt is OR of flags with enables
package qcmd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_POS_COUNT      = 8'h00;
  localparam logic [7:0] OFS_POS_COMPARE    = 8'h04;
  localparam logic [7:0] OFS_SHARED_COMPARE = 8'h08;
  localparam logic [7:0] OFS_CONTROL        = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CONTROL    = 8'h10;
  localparam logic [7:0] OFS_MAX_POSITION   = 8'h14;
  localparam logic [7:0] OFS_REV_COUNT      = 8'h18;

  // Control register fields
  localparam int CTL_POS_MODE_LSB   = 0;
  localparam int CTL_REV_MODE_LSB   = 2;
  localparam int CTL_TARGET_SEL_BIT = 4;

  // Interrupt control fields
  localparam int IRQ_OVERFLOW_BIT   = 0;
  localparam int IRQ_UNDERFLOW_BIT  = 1;
  localparam int IRQ_WRAP_EN_BIT    = 2;
  localparam int IRQ_REVERSAL_EN_BIT = 8;
  localparam int IRQ_REVERSAL_BIT   = 9;
  localparam int IRQ_STEP_DIR_BIT   = 10;
  localparam int IRQ_WRAP_DIR_BIT   = 11;
  localparam int IRQ_BOTH_EN_BIT    = 12;
  localparam int IRQ_BOTH_MATCH_BIT = 13;

  // Values after reset
  localparam logic [15:0] MAX_POSITION_RESET = 16'hffff;
  localparam logic [1:0]  MODE_RESET         = 2'h0;
  localparam logic [15:0] COUNT_RESET        = 16'h0000;

  // Position counter modes
  localparam logic [1:0] POS_DISABLED_MODE = 2'h0;
  localparam logic [1:0] POS_UPDOWN_MODE   = 2'h1;
  localparam logic [1:0] POS_PHASE_MODE    = 2'h2;
  localparam logic [1:0] POS_DIR_MODE      = 2'h3;

  // Revolution counter modes
  localparam logic [1:0] REV_DISABLED_MODE = 2'h0;
  localparam logic [1:0] REV_INDEX_MODE    = 2'h1;
  localparam logic [1:0] REV_WRAP_MODE     = 2'h2;
  localparam logic [1:0] REV_BOTH_MODE     = 2'h3;

  // AHB-Lite encodings
  localparam int         HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_BYTE        = 3'h0;

  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ACCESS = 2'b10
  } qcmd_bus_state_type;

endpackage

// ==== core/qcmd_reg_if.sv ====
// Register access carrier between the bus slave and the register file.
// Assumes one write strobe per access and read data sampled by the slave.
`timescale 1ns/10ps
interface qcmd_reg_if;
  logic        wr;        // One-cycle write strobe
  logic [7:0]  addr;      // Byte offset in the window
  logic [31:0] wdata;
  logic        byte_acc;  // Access was byte sized
  logic        locked;    // Locked read-modify-write access
  logic [31:0] rdata;

  modport slave (output wr, addr, wdata, byte_acc, locked, input rdata);
  modport regs  (input wr, addr, wdata, byte_acc, locked, output rdata);
endinterface // qcmd_reg_if

// ==== core/qcmd_ahb_slave.sv ====
// AHB-Lite slave front end with one wait state per transfer.
// Assumes single word transfers; answer is always OKAY.
`timescale 1ns/10ps
module qcmd_ahb_slave (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // AHB-Lite
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hmastlock_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Register side
  qcmd_reg_if.slave        bus
);

  qcmd_pkg::qcmd_bus_state_type state;
  logic write_q;

  // Address phase capture; wait state keeps hrdata registered
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state        <= qcmd_pkg::BUS_IDLE;
      write_q      <= 1'b0;
      bus.addr     <= 8'h00;
      bus.byte_acc <= 1'b0;
      bus.locked   <= 1'b0;
      hreadyout_o  <= 1'b1;
      hrdata_o     <= 32'h0000_0000;
      hresp_o      <= 1'b0; // OKAY only, never raised
    end else begin
      unique case (state)
        qcmd_pkg::BUS_IDLE: begin
          if (hsel_i && htrans_i[qcmd_pkg::HTRANS_ACTIVE_BIT] && hready_i) begin
            state        <= qcmd_pkg::BUS_ACCESS;
            write_q      <= hwrite_i;
            bus.addr     <= haddr_i[7:0];
            bus.byte_acc <= (hsize_i == qcmd_pkg::HSIZE_BYTE);
            bus.locked   <= hmastlock_i;
            hreadyout_o  <= 1'b0;
          end
        end
        qcmd_pkg::BUS_ACCESS: begin
          state       <= qcmd_pkg::BUS_IDLE;
          hreadyout_o <= 1'b1;
          if (!write_q) begin
            hrdata_o <= bus.rdata;
          end
        end
      endcase
    end
  end

  // Write lands at the end of the wait state
  assign bus.wr    = (state == qcmd_pkg::BUS_ACCESS) && write_q;
  assign bus.wdata = hwdata_i;

endmodule // qcmd_ahb_slave

// ==== core/qcmd_quad_decode.sv ====
// Turns encoder phase and index levels into step and index pulses.
// Assumes inputs are already synchronous to the clock.
`timescale 1ns/10ps
module qcmd_quad_decode (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // Encoder
  input  wire logic       phase_a_input_i,
  input  wire logic       phase_b_input_i,
  input  wire logic       index_input_i,
  input  wire logic [1:0] pos_mode_i,
  // Events
  output logic            step_up_o,
  output logic            step_dn_o,
  output logic            index_edge_o
);

  logic a_q, b_q, z_q, a_rise, b_rise, one_moved;

  // Previous levels for edge detection
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      z_q <= 1'b0;
    end else begin
      a_q <= phase_a_input_i;
      b_q <= phase_b_input_i;
      z_q <= index_input_i;
    end
  end

  assign a_rise    = phase_a_input_i & ~a_q;
  assign b_rise    = phase_b_input_i & ~b_q;
  // Both phases moving at once is a glitch and is dropped in phase mode
  assign one_moved = (phase_a_input_i ^ a_q) ^ (phase_b_input_i ^ b_q);

  // Step decoding per position mode
  always_comb begin
    step_up_o = 1'b0;
    step_dn_o = 1'b0;
    unique case (pos_mode_i)
      qcmd_pkg::POS_DISABLED_MODE: begin
      end
      qcmd_pkg::POS_UPDOWN_MODE: begin
        step_up_o = a_rise & ~b_rise;
        step_dn_o = b_rise & ~a_rise;
      end
      qcmd_pkg::POS_PHASE_MODE: begin
        step_up_o = one_moved & (phase_a_input_i ^ b_q);
        step_dn_o = one_moved & ~(phase_a_input_i ^ b_q);
      end
      qcmd_pkg::POS_DIR_MODE: begin
        step_up_o = a_rise & ~phase_b_input_i;
        step_dn_o = a_rise & phase_b_input_i;
      end
    endcase
  end

  assign index_edge_o = index_input_i & ~z_q &
                        (pos_mode_i != qcmd_pkg::POS_DISABLED_MODE);

endmodule // qcmd_quad_decode

// ==== core/qcmd_top.sv ====
// Position and revolution counters with match, direction and wrap flags.
// Assumes synchronous encoder inputs and a single AHB-Lite master.
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module qcmd_top #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hmastlock_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Encoder
  input  wire logic        phase_a_input_i,
  input  wire logic        phase_b_input_i,
  input  wire logic        index_input_i,
  // Interrupt
  output logic             irq_o
);

  if (CNT_W < 2 || CNT_W > 16) begin : g_width_check
    $error("CNT_W must lie between 2 and 16");
  end

  // Reset release synchroniser
  logic [1:0] rst_pipe;
  logic       rst_b;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_b = rst_pipe[1];

  qcmd_reg_if bus ();

  qcmd_ahb_slave u_slave (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hmastlock_i (hmastlock_i),
    .hready_i    (hready_i),
    .hwdata_i    (hwdata_i),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .bus         (bus)
  );

  // Software state
  logic [CNT_W-1:0] pos_cnt;
  logic [CNT_W-1:0] pos_cmp;
  logic [CNT_W-1:0] shared_cmp;
  logic [CNT_W-1:0] max_pos;
  logic [CNT_W-1:0] rev_cnt;
  logic [1:0]       pos_mode;
  logic [1:0]       rev_mode;
  logic [1:0]       pos_mode_prev;
  logic [1:0]       rev_mode_prev;
  logic             compare_target_select;
  // Flags and enables
  logic             overflow_flag;
  logic             underflow_flag;
  logic             wrap_irq_enable;
  logic             both_match_flag;
  logic             both_match_irq_enable;
  logic             last_wrap_direction;
  logic             last_step_direction;
  logic             direction_reversal_flag;
  logic             direction_reversal_irq_enable;
  logic             dir_valid;
  logic             trig_q;

  // Register hit decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_pos;
  logic wr_pcmp;
  logic wr_scmp;
  logic wr_ctrl;
  logic wr_irq;
  logic wr_max;
  logic [CNT_W-1:0] wval;

  assign wr_pos  = bus.wr && hit(bus.addr, qcmd_pkg::OFS_POS_COUNT);
  assign wr_pcmp = bus.wr && hit(bus.addr, qcmd_pkg::OFS_POS_COMPARE);
  assign wr_scmp = bus.wr && hit(bus.addr, qcmd_pkg::OFS_SHARED_COMPARE);
  assign wr_ctrl = bus.wr && hit(bus.addr, qcmd_pkg::OFS_CONTROL);
  assign wr_irq  = bus.wr && hit(bus.addr, qcmd_pkg::OFS_IRQ_CONTROL);
  assign wr_max  = bus.wr && hit(bus.addr, qcmd_pkg::OFS_MAX_POSITION);
  assign wval    = bus.wdata[CNT_W-1:0];

  // Encoder events
  logic step_up;
  logic step_dn;
  logic index_edge;

  qcmd_quad_decode u_decode (
    .mclk_i          (mclk_i),
    .rst_b_i         (rst_b),
    .phase_a_input_i (phase_a_input_i),
    .phase_b_input_i (phase_b_input_i),
    .index_input_i   (index_input_i),
    .pos_mode_i      (pos_mode),
    .step_up_o       (step_up),
    .step_dn_o       (step_dn),
    .index_edge_o    (index_edge)
  );

  logic step;
  logic ovf;
  logic unf;
  logic idx_reset;
  logic rev_index_cnt;
  logic rev_wrap_cnt;

  assign step = step_up | step_dn;
  assign ovf  = step_up && (pos_cnt == max_pos); // RL18
  assign unf  = step_dn && (pos_cnt == '0);
  // Index clears position except in wrap-count revolution mode
  assign idx_reset = index_edge && (rev_mode != qcmd_pkg::REV_WRAP_MODE);
  // No known direction, no index count
  assign rev_index_cnt = index_edge && dir_valid && // RL13
                         rev_mode[0];
  assign rev_wrap_cnt  = (ovf | unf) && rev_mode[1];

  // Control register
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      pos_mode              <= qcmd_pkg::MODE_RESET;
      rev_mode              <= qcmd_pkg::MODE_RESET;
      compare_target_select <= 1'b0;
    end else if (wr_ctrl) begin
      pos_mode <= bus.wdata[qcmd_pkg::CTL_POS_MODE_LSB +: 2];
      rev_mode <= bus.wdata[qcmd_pkg::CTL_REV_MODE_LSB +: 2];
      compare_target_select <= bus.wdata[qcmd_pkg::CTL_TARGET_SEL_BIT];
    end
  end

  // Compare values and maximum position
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      pos_cmp    <= CNT_W'(qcmd_pkg::COUNT_RESET);
      shared_cmp <= CNT_W'(qcmd_pkg::COUNT_RESET);
      max_pos    <= CNT_W'(qcmd_pkg::MAX_POSITION_RESET); // RL17
    end else begin
      if (wr_pcmp) begin
        pos_cmp <= wval;
      end
      if (wr_scmp) begin
        shared_cmp <= wval;
      end
      // Byte writes are dropped; only halfword or word may land
      if (wr_max && !bus.byte_acc) begin // RL20
        max_pos <= wval; // RL17
      end
    end
  end

  // Position counter; a software write wins over a step
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      pos_cnt <= CNT_W'(qcmd_pkg::COUNT_RESET);
    end else if (wr_pos) begin
      pos_cnt <= wval;
    end else if (idx_reset) begin
      pos_cnt <= '0; // RL13
    end else if (ovf) begin
      pos_cnt <= '0;
    end else if (unf) begin
      pos_cnt <= max_pos; // RL19
    end else if (step_up) begin
      pos_cnt <= pos_cnt + 1'b1;
    end else if (step_dn) begin
      pos_cnt <= pos_cnt - 1'b1;
    end
  end

  // Revolution counter; index count beats wrap
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      rev_cnt <= CNT_W'(qcmd_pkg::COUNT_RESET);
    end else if (rev_index_cnt) begin
      rev_cnt <= last_step_direction ? rev_cnt - 1'b1 : rev_cnt + 1'b1;
    end else if (rev_wrap_cnt) begin
      rev_cnt <= ovf ? rev_cnt + 1'b1 : rev_cnt - 1'b1;
    end
  end

  // Direction tracking; mode 00 forgets the last direction
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      dir_valid           <= 1'b0;
      last_step_direction <= 1'b0;
      last_wrap_direction <= 1'b0;
    end else begin
      if (pos_mode == qcmd_pkg::POS_DISABLED_MODE) begin
        dir_valid <= 1'b0; // RL13
      end else if (step) begin
        dir_valid <= 1'b1;
      end
      if (step) begin
        last_step_direction <= step_dn; // RL12
      end
      if (ovf | unf) begin
        last_wrap_direction <= unf; // RL11
      end
    end
  end

  // Match checked one cycle after an operand moves
  logic pos_enter;
  logic rev_enter;
  logic both_set;
  logic reversal_set;

  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      trig_q        <= 1'b0;
      pos_mode_prev <= qcmd_pkg::MODE_RESET;
      rev_mode_prev <= qcmd_pkg::MODE_RESET;
    end else begin
      trig_q <= step | index_edge | wr_pos | wr_pcmp | wr_scmp; // RL6 RL7
      pos_mode_prev <= pos_mode;
      rev_mode_prev <= rev_mode;
    end
  end

  assign pos_enter = (pos_mode_prev == qcmd_pkg::POS_DISABLED_MODE) &&
                     (pos_mode != qcmd_pkg::POS_DISABLED_MODE); // RL5
  assign rev_enter = (rev_mode_prev == qcmd_pkg::REV_DISABLED_MODE) &&
                     (rev_mode != qcmd_pkg::REV_DISABLED_MODE); // RL8
  // Target select plays no part here
  assign both_set = (trig_q | pos_enter | rev_enter) && // RL9
                    (pos_mode != qcmd_pkg::POS_DISABLED_MODE) &&
                    (rev_mode != qcmd_pkg::REV_DISABLED_MODE) &&
                    (pos_cnt == pos_cmp) && (rev_cnt == shared_cmp); // RL2
  assign reversal_set = step && dir_valid && // RL15
                        (step_dn != last_step_direction); // RL14

  // Sticky flags: write zero clears, set wins over clear
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      both_match_flag         <= 1'b0;
      direction_reversal_flag <= 1'b0;
      overflow_flag           <= 1'b0;
      underflow_flag          <= 1'b0;
    end else begin
      both_match_flag <= both_set | (both_match_flag & // RL3
        ~(wr_irq & ~bus.wdata[qcmd_pkg::IRQ_BOTH_MATCH_BIT]));
      direction_reversal_flag <= reversal_set | (direction_reversal_flag &
        ~(wr_irq & ~bus.wdata[qcmd_pkg::IRQ_REVERSAL_BIT])); // RL3
      overflow_flag <= ovf | (overflow_flag & // RL18
        ~(wr_irq & ~bus.wdata[qcmd_pkg::IRQ_OVERFLOW_BIT]));
      underflow_flag <= unf | (underflow_flag &
        ~(wr_irq & ~bus.wdata[qcmd_pkg::IRQ_UNDERFLOW_BIT]));
    end
  end

  // Interrupt enables
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      both_match_irq_enable         <= 1'b0;
      direction_reversal_irq_enable <= 1'b0;
      wrap_irq_enable               <= 1'b0;
    end else if (wr_irq) begin
      both_match_irq_enable <= bus.wdata[qcmd_pkg::IRQ_BOTH_EN_BIT];
      direction_reversal_irq_enable <=
        bus.wdata[qcmd_pkg::IRQ_REVERSAL_EN_BIT];
      wrap_irq_enable <= bus.wdata[qcmd_pkg::IRQ_WRAP_EN_BIT];
    end
  end

  // Registered so the pin never glitches
  always_ff @(posedge mclk_i or negedge rst_b) begin
    if (!rst_b) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (both_match_flag & both_match_irq_enable) | // RL10 RL21
               (direction_reversal_flag &
                direction_reversal_irq_enable) | // RL16
               ((overflow_flag | underflow_flag) & wrap_irq_enable);
    end
  end

  // Locked reads show flags as one
  logic [15:0] irq_image;

  always_comb begin
    irq_image = 16'h0000; // RL1
    irq_image[qcmd_pkg::IRQ_BOTH_MATCH_BIT]  = both_match_flag | bus.locked;
    irq_image[qcmd_pkg::IRQ_BOTH_EN_BIT]     = both_match_irq_enable;
    irq_image[qcmd_pkg::IRQ_WRAP_DIR_BIT]    = last_wrap_direction;
    irq_image[qcmd_pkg::IRQ_STEP_DIR_BIT]    = last_step_direction;
    irq_image[qcmd_pkg::IRQ_REVERSAL_BIT]    =
      direction_reversal_flag | bus.locked; // RL4
    irq_image[qcmd_pkg::IRQ_REVERSAL_EN_BIT] = direction_reversal_irq_enable;
    irq_image[qcmd_pkg::IRQ_WRAP_EN_BIT]     = wrap_irq_enable;
    irq_image[qcmd_pkg::IRQ_OVERFLOW_BIT]    = overflow_flag | bus.locked;
    irq_image[qcmd_pkg::IRQ_UNDERFLOW_BIT]   = underflow_flag | bus.locked;
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    bus.rdata = 32'h0000_0000;
    case (bus.addr)
      qcmd_pkg::OFS_POS_COUNT:      bus.rdata = 32'(pos_cnt);
      qcmd_pkg::OFS_POS_COMPARE:    bus.rdata = 32'(pos_cmp);
      qcmd_pkg::OFS_SHARED_COMPARE: bus.rdata = 32'(shared_cmp);
      qcmd_pkg::OFS_CONTROL: begin
        bus.rdata[qcmd_pkg::CTL_POS_MODE_LSB +: 2]  = pos_mode;
        bus.rdata[qcmd_pkg::CTL_REV_MODE_LSB +: 2]  = rev_mode;
        bus.rdata[qcmd_pkg::CTL_TARGET_SEL_BIT]     = compare_target_select;
      end
      qcmd_pkg::OFS_IRQ_CONTROL:    bus.rdata = 32'(irq_image);
      qcmd_pkg::OFS_MAX_POSITION:   bus.rdata = 32'(max_pos);
      qcmd_pkg::OFS_REV_COUNT:      bus.rdata = 32'(rev_cnt);
      default:                      bus.rdata = 32'h0000_0000;
    endcase
  end

endmodule // qcmd_top

// ==== sim/qcmd_asserts.sv ====
// Bus-visible checks for the match/direction block.
// Assumes the bench feeds hreadyout_o back as hready_i.
`timescale 1ns/10ps
module qcmd_asserts #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  // Bus
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic        hmastlock_i,
  input wire logic        hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // Interrupt
  input wire logic        irq_o
);
  logic        taken;
  logic        max_pend;
  logic [15:0] max_shadow;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // Transfer accepted in an address phase
  assign taken = hsel_i & htrans_i[1] & hready_i;

  // Limit shadow from non-byte writes
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      max_pend   <= 1'b0;
      max_shadow <= qcmd_pkg::MAX_POSITION_RESET;
    end else if (taken) begin
      max_pend <= hwrite_i & (hsize_i != qcmd_pkg::HSIZE_BYTE)
                  & (haddr_i[7:0] == qcmd_pkg::OFS_MAX_POSITION);
    end else if (max_pend & !hreadyout_o) begin
      max_pend   <= 1'b0;
      max_shadow <= hwdata_i[15:0];
    end
  end

  // Read from address phase to data valid
  sequence s_read(logic [7:0] ofs, logic lk);
    taken && !hwrite_i && haddr_i[7:0] == ofs && hmastlock_i == lk
    ##1 !hreadyout_o ##1 hreadyout_o;
  endsequence

  property p_reserved;
    s_read(qcmd_pkg::OFS_IRQ_CONTROL, 1'b0) |-> hrdata_o[15:14] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits read nonzero");

  property p_locked;
    s_read(qcmd_pkg::OFS_IRQ_CONTROL, 1'b1)
      |-> (hrdata_o[15:0] & 16'he203) == 16'h2203;
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked read did not show flags as one");

  property p_max;
    s_read(qcmd_pkg::OFS_MAX_POSITION, 1'b0)
      |-> hrdata_o == {16'h0000, max_shadow};
  endproperty
  a_max: assert property (p_max)
    else $error("limit register read wrong value");

  property p_irq_on;
    s_read(qcmd_pkg::OFS_IRQ_CONTROL, 1'b0) ##0
      ((hrdata_o[13] & hrdata_o[12]) | (hrdata_o[9] & hrdata_o[8]))
      |-> ##[0:1] irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled flag raised no interrupt");

  property p_irq_off;
    s_read(qcmd_pkg::OFS_IRQ_CONTROL, 1'b0) ##0
      (hrdata_o[12] | hrdata_o[8] | hrdata_o[2]) == 1'b0 |-> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt with all enables off");

  property p_one_wait;
    taken |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("transfer wait state not exactly one");

  property p_okay;
    hresp_o == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("response not OKAY");

  property p_hold;
    hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved between reads");
endmodule // qcmd_asserts

bind qcmd_top qcmd_asserts #(.CNT_W(CNT_W)) u_chk (.mclk_i, .rst_b_i,
  .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hmastlock_i,
  .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .irq_o);

// ==== sim/qcmd_encoder_model.sv ====
// Rotary encoder stand-in pulsing phase A, phase B or index.
// Assumes each pulse is started just after a rising clock edge.
`timescale 1ns/10ps
module qcmd_encoder_model (
  // Clock
  input  wire logic mclk_i,
  // Encoder lines, low between pulses
  output logic      phase_a_o,
  output logic      phase_b_o,
  output logic      index_o
);
  // Lines rest low before any pulse
  initial {index_o, phase_b_o, phase_a_o} = 3'h0;

  // Long hold mimics a slow shaft; gap keeps edges apart
  task automatic pulse(input int line, input int hold);
    {index_o, phase_b_o, phase_a_o} <= 3'h1 << line;
    repeat (hold) @(posedge mclk_i);
    {index_o, phase_b_o, phase_a_o} <= 3'h0;
    repeat (2) @(posedge mclk_i);
  endtask
endmodule // qcmd_encoder_model

// ==== sim/quad_counter_match_direction_test.sv ====
// Register-level tests of the match/direction block.
// Assumes the checker is bound and the encoder model drives the phases.
`timescale 1ns/10ps
module quad_counter_match_direction_test;
  localparam PCNT = qcmd_pkg::OFS_POS_COUNT;
  localparam PCMP = qcmd_pkg::OFS_POS_COMPARE;
  localparam SCMP = qcmd_pkg::OFS_SHARED_COMPARE;
  localparam CTL  = qcmd_pkg::OFS_CONTROL;
  localparam IRQ  = qcmd_pkg::OFS_IRQ_CONTROL;
  localparam MAXP = qcmd_pkg::OFS_MAX_POSITION;
  localparam RCNT = qcmd_pkg::OFS_REV_COUNT;
  logic        mclk_i, rst_b_i, hsel_i, hwrite_i, hmastlock_i, hreadyout_o;
  logic        hresp_o, enc_a, enc_b, enc_z, irq_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [2:0]  hsize_i;
  logic [1:0]  htrans_i;
  int          error_cnt = 0;
  int          num_checks = 0;

  qcmd_top DUT (.mclk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i, .hmastlock_i, .hready_i(hreadyout_o), .hwdata_i, .hrdata_o,
    .hreadyout_o, .hresp_o, .phase_a_input_i(enc_a),
    .phase_b_input_i(enc_b), .index_input_i(enc_z), .irq_o);
  qcmd_encoder_model enc (.mclk_i, .phase_a_o(enc_a), .phase_b_o(enc_b),
    .index_o(enc_z));

  // 20 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One word transfer, paced by hready
  task automatic bus(input logic [7:0] ofs, input logic wr, lk,
                     input logic [31:0] wd, output logic [31:0] rd);
    haddr_i     <= {24'h0, ofs};
    htrans_i    <= 2'h2;
    hwrite_i    <= wr;
    hmastlock_i <= lk;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    bus(ofs, 1'b1, 1'b0, d, x);
  endtask

  task automatic rdc(input string n, input logic [7:0] ofs,
                     input logic [31:0] m, e, input logic lk = 1'b0);
    logic [31:0] x;
    bus(ofs, 1'b0, lk, 32'h0, x);
    check(n, x & m, e);
  endtask

  // Interrupt lags its flag by one edge
  task automatic irqc(input logic e);
    @(posedge mclk_i);
    check("irq", {31'h0, irq_o}, {31'h0, e});
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Whole run is under two hundred cycles
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    rst_b_i = 1'b0;
    hsel_i = 1'b1;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    hmastlock_i = 1'b0;
    hwdata_i = 32'h0;
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    // Reset values
    rdc("irq_ctl", IRQ, 32'hffff, 32'h0);
    rdc("max_pos", MAXP, 32'hffffffff, 32'hffff);
    // Wrap at zero and at a small limit
    wr(MAXP, 32'h3);
    rdc("max_pos", MAXP, 32'hffffffff, 32'h3);
    wr(CTL, 32'h5);
    enc.pulse(1, 1);
    rdc("pos_cnt", PCNT, 32'hffff, 32'h3);
    rdc("dirs", IRQ, 32'he03, 32'hc02);
    enc.pulse(0, 3);
    rdc("pos_cnt", PCNT, 32'hffff, 32'h0);
    rdc("dirs", IRQ, 32'he03, 32'h203);
    rdc("locked", IRQ, 32'he203, 32'h2203, 1'b1);
    // Ones written keep flags; zeros clear them
    wr(IRQ, 32'h2303);
    irqc(1'b1);
    rdc("kept", IRQ, 32'h303, 32'h303);
    wr(IRQ, 32'h0);
    rdc("cleared", IRQ, 32'hffff, 32'h0);
    irqc(1'b0);
    // Combined match sources
    wr(CTL, 32'h0);
    wr(PCNT, 32'h2);
    wr(PCMP, 32'h2);
    wr(SCMP, 32'h0);
    wr(IRQ, 32'h1000);
    wr(CTL, 32'h5);
    rdc("entry", IRQ, 32'h2000, 32'h2000);
    irqc(1'b1);
    wr(IRQ, 32'h0);
    wr(PCNT, 32'h2);
    rdc("cnt_wr", IRQ, 32'h2000, 32'h2000);
    wr(IRQ, 32'h0);
    wr(PCMP, 32'h7);
    rdc("no_match", IRQ, 32'h2000, 32'h0);
    wr(PCMP, 32'h2);
    wr(IRQ, 32'h0);
    wr(SCMP, 32'h0);
    rdc("shr_wr", IRQ, 32'h2000, 32'h2000);
    wr(CTL, 32'h11);
    wr(IRQ, 32'h0);
    wr(CTL, 32'h15);
    rdc("rev_on", IRQ, 32'h2000, 32'h2000);
    // Index before first step
    wr(CTL, 32'h0);
    wr(CTL, 32'h5);
    enc.pulse(2, 1);
    rdc("pos_cnt", PCNT, 32'hffff, 32'h0);
    rdc("rev_cnt", RCNT, 32'hffff, 32'h0);
    enc.pulse(0, 1);
    enc.pulse(2, 1);
    rdc("rev_cnt", RCNT, 32'hffff, 32'h1);
    // Direction mode: A rise with B low counts up
    wr(CTL, 32'h7);
    enc.pulse(0, 1);
    rdc("mode3", PCNT, 32'hffff, 32'h1);
    print_verdict();
  end
endmodule // quad_counter_match_direction_test
